// >>> inc/gpio_port_pkg.sv
// Shared constants, register map and bus carrier for the GPIO port
package gpio_port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses within the 1 MiB slot)
  localparam logic [7:0] OFS_INPUT_VALUE    = 8'h00;
  localparam logic [7:0] OFS_OUTPUT_VALUE   = 8'h04;
  localparam logic [7:0] OFS_LINE_DIRECTION = 8'h08;
  localparam logic [7:0] OFS_IRQ_ENABLE     = 8'h0C;
  localparam logic [7:0] OFS_IRQ_POLARITY   = 8'h10;
  localparam logic [7:0] OFS_IRQ_EDGE       = 8'h14;
  localparam logic [7:0] OFS_ALT_OUTPUT_SEL = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode fields
  localparam int          BASE_LSB  = 20;
  localparam int          WORD_MSB  = 7;
  localparam int          WORD_LSB  = 2;
  localparam int          MAX_LINES = 32;
  localparam int          DEF_LINES = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0] RST_REG   = 32'h0000_0000;
  localparam logic [31:0] RST_SYNC  = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // APB request carrier
  typedef struct packed {
    logic [31:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

// >>> rtl/gpio_port_apb.sv
// GPIO port with APB register slave, per-line interrupts and pin sharing
module gpio_port_apb #(
  parameter int          NBITS      = gpio_port_pkg::DEF_LINES,
  parameter logic [11:0] BASE_ADDR  = 12'h000,
  parameter logic [11:0] ADDR_MASK  = 12'hFFF,
  parameter logic [31:0] IRQ_CAP    = 32'h0000_0000,
  parameter logic [31:0] SHARE_OUT  = 32'h0000_0000,
  parameter logic [31:0] SHARE_DIR  = 32'h0000_0000,
  parameter bit          OE_POL     = 1'b0,
  parameter bit          SYNC_RESET = 1'b0,
  // Identifier values are arbitrary
  parameter logic [7:0]  VENDOR_ID  = 8'h5A,
  parameter logic [11:0] DEVICE_ID  = 12'h0A5
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst,
  // APB slave
  input  wire gpio_port_pkg::apb_req_t apb_req,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Pads
  input  wire logic [31:0]            pad_in,
  output logic [31:0]                 pad_out,
  output logic [31:0]                 pad_oe,
  // Pin sharing
  input  wire logic [31:0]            alternate_output_value,
  input  wire logic [31:0]            alternate_output_enable,
  output logic [31:0]                 raw_input_vector,
  output logic [31:0]                 synced_input_vector,
  // Interrupts and identity
  output logic [31:0]                 irq,
  output logic [7:0]                  pnp_vendor,
  output logic [11:0]                 pnp_device
);

  ////////////////////////////////////////////////////////////////////////////
  // Line mask
  function automatic logic [31:0] line_mask(input int n);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < gpio_port_pkg::MAX_LINES; i++) begin
      m[i] = (i < n);
    end
    return m;
  endfunction

  localparam logic [31:0] LMASK = line_mask(NBITS);

  ////////////////////////////////////////////////////////////////////////////
  // Reset style: only one of the two terms is ever live
  wire logic arst = SYNC_RESET ? 1'b0 : rst;
  wire logic srst = SYNC_RESET ? rst : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [31:0] sync_stage1;
  logic [31:0] sync_stage2;
  logic [31:0] sync_prev;
  logic [31:0] output_value;
  logic [31:0] line_direction;
  logic [31:0] irq_enable_mask;
  logic [31:0] irq_polarity;
  logic [31:0] irq_edge_select;
  logic [31:0] alt_output_select;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire logic        hit      = apb_req.psel &&
                               ((apb_req.paddr[31:gpio_port_pkg::BASE_LSB] & ADDR_MASK)
                                == (BASE_ADDR & ADDR_MASK));
  wire logic        setup_rd = hit && !apb_req.penable && !apb_req.pwrite;
  wire logic        acc_wr   = hit && apb_req.penable && apb_req.pwrite;
  wire logic [7:0]  ofs      = {apb_req.paddr[gpio_port_pkg::WORD_MSB:gpio_port_pkg::WORD_LSB],
                                2'b00};
  wire logic [31:0] wdata    = apb_req.pwdata & LMASK;

  wire logic wr_out  = acc_wr && (ofs == gpio_port_pkg::OFS_OUTPUT_VALUE);
  wire logic wr_dir  = acc_wr && (ofs == gpio_port_pkg::OFS_LINE_DIRECTION);
  wire logic wr_ien  = acc_wr && (ofs == gpio_port_pkg::OFS_IRQ_ENABLE);
  wire logic wr_pol  = acc_wr && (ofs == gpio_port_pkg::OFS_IRQ_POLARITY);
  wire logic wr_edge = acc_wr && (ofs == gpio_port_pkg::OFS_IRQ_EDGE);
  wire logic wr_alt  = acc_wr && (ofs == gpio_port_pkg::OFS_ALT_OUTPUT_SEL);

  // Unmapped offsets read zero; data offset ignores writes
  logic [31:0] next_rdata;
  always_comb begin
    unique case (ofs)
      gpio_port_pkg::OFS_INPUT_VALUE:    next_rdata = sync_stage2;
      gpio_port_pkg::OFS_OUTPUT_VALUE:   next_rdata = output_value;
      gpio_port_pkg::OFS_LINE_DIRECTION: next_rdata = line_direction;
      gpio_port_pkg::OFS_IRQ_ENABLE:     next_rdata = irq_enable_mask;
      gpio_port_pkg::OFS_IRQ_POLARITY:   next_rdata = irq_polarity;
      gpio_port_pkg::OFS_IRQ_EDGE:       next_rdata = irq_edge_select;
      gpio_port_pkg::OFS_ALT_OUTPUT_SEL: next_rdata = alt_output_select;
      default:                           next_rdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation; stage 1 is read only by stage 2
  always_ff @(posedge mclk or posedge arst) begin
    if (arst || srst) begin
      sync_stage1 <= gpio_port_pkg::RST_SYNC;
      sync_stage2 <= gpio_port_pkg::RST_SYNC;
      sync_prev   <= gpio_port_pkg::RST_SYNC;
    end else begin
      sync_stage1 <= pad_in & LMASK;
      sync_stage2 <= sync_stage1;
      sync_prev   <= sync_stage2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and read data
  always_ff @(posedge mclk or posedge arst) begin
    if (arst || srst) begin
      output_value      <= gpio_port_pkg::RST_REG;
      line_direction    <= gpio_port_pkg::RST_REG;
      irq_enable_mask   <= gpio_port_pkg::RST_REG;
      irq_polarity      <= gpio_port_pkg::RST_REG;
      irq_edge_select   <= gpio_port_pkg::RST_REG;
      alt_output_select <= gpio_port_pkg::RST_REG;
      prdata            <= gpio_port_pkg::RST_REG;
    end else begin
      if (wr_out)  output_value      <= wdata;
      if (wr_dir)  line_direction    <= wdata;
      if (wr_ien)  irq_enable_mask   <= wdata;
      if (wr_pol)  irq_polarity      <= wdata;
      if (wr_edge) irq_edge_select   <= wdata;
      if (wr_alt)  alt_output_select <= wdata;
      // Captured in setup phase so the access phase needs no wait
      if (setup_rd) begin
        prdata <= next_rdata;
      end else if (!hit) begin
        prdata <= gpio_port_pkg::RST_REG;
      end
    end
  end

  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: line n drives bit n of the vector
  wire logic [31:0] level_act = ~(sync_stage2 ^ irq_polarity);
  wire logic [31:0] rise      = sync_stage2 & ~sync_prev;
  wire logic [31:0] fall      = ~sync_stage2 & sync_prev;
  wire logic [31:0] edge_act  = (irq_polarity & rise) | (~irq_polarity & fall);
  wire logic [31:0] next_irq  = ((irq_edge_select & edge_act) |
                                 (~irq_edge_select & level_act)) &
                                irq_enable_mask & IRQ_CAP & LMASK;

  always_ff @(posedge mclk or posedge arst) begin
    if (arst || srst) begin
      irq <= gpio_port_pkg::RST_REG;
    end else begin
      irq <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive and sharing
  wire logic [31:0] alt_sel   = alt_output_select & SHARE_OUT;
  wire logic [31:0] oe_active = (line_direction |
                                 (alternate_output_enable & SHARE_DIR)) & LMASK;

  assign pad_out = ((alt_sel & alternate_output_value) |
                    (~alt_sel & output_value)) & LMASK;
  assign pad_oe  = OE_POL ? oe_active : ~oe_active;

  assign raw_input_vector    = pad_in & LMASK;
  assign synced_input_vector = sync_stage2;
  assign pnp_vendor          = VENDOR_ID;
  assign pnp_device          = DEVICE_ID;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_sync_two_stage: assert property (
    @(posedge mclk) disable iff (rst)
    !$past(rst, 1) && !$past(rst, 2) |->
      synced_input_vector == ($past(pad_in, 2) & LMASK))
    else $error("synced input is not pad input delayed two cycles");

  a_dir_enables_oe: assert property (
    @(posedge mclk) disable iff (rst)
    (line_direction & LMASK & ~(OE_POL ? pad_oe : ~pad_oe)) == 32'h0000_0000)
    else $error("direction bit set but output buffer is off");

  // Buffers stay off unless direction or a shared enable asks for them
  a_oe_off_idle: assert property (
    @(posedge mclk) disable iff (rst)
    ((OE_POL ? pad_oe : ~pad_oe) & ~line_direction &
     ~(alternate_output_enable & SHARE_DIR)) == 32'h0000_0000)
    else $error("output buffer on without direction or alternate enable");

  a_alt_enables_oe: assert property (
    @(posedge mclk) disable iff (rst)
    (alternate_output_enable & SHARE_DIR & LMASK &
     ~(OE_POL ? pad_oe : ~pad_oe)) == 32'h0000_0000)
    else $error("alternate enable does not turn on shared buffer");

  a_alt_out_mux: assert property (
    @(posedge mclk) disable iff (rst)
    ((pad_out ^ alternate_output_value) & alt_output_select & SHARE_OUT & LMASK) ==
      32'h0000_0000)
    else $error("bypassed line does not drive alternate value");

  a_norm_out_drive: assert property (
    @(posedge mclk) disable iff (rst)
    ((pad_out ^ output_value) & ~(alt_output_select & SHARE_OUT) & LMASK) ==
      32'h0000_0000)
    else $error("pad output does not follow output register");

  a_irq_gated: assert property (
    @(posedge mclk) disable iff (rst)
    (irq & ~($past(irq_enable_mask) & IRQ_CAP)) == 32'h0000_0000)
    else $error("interrupt on masked or incapable line");

  // Settings are compared across both cycles, since software may turn a
  // level line into an edge line while its interrupt is active
  a_edge_one_cycle: assert property (
    @(posedge mclk) disable iff (rst)
    (irq & $past(irq) & $past(irq_edge_select) & $past(irq_edge_select, 2) &
     ~($past(irq_polarity) ^ $past(irq_polarity, 2))) == 32'h0000_0000)
    else $error("edge interrupt lasted more than one cycle");

  // Previous sample rebuilt from the synchronised value, not from sync_prev
  a_rise_pulse_fires: assert property (
    @(posedge mclk) disable iff (rst)
    ($past(sync_stage2) & ~$past(sync_stage2, 2) & $past(irq_polarity) &
     $past(irq_edge_select) & $past(irq_enable_mask) & IRQ_CAP & LMASK & ~irq) ==
      32'h0000_0000)
    else $error("rising edge interrupt missing");

  a_fall_pulse_fires: assert property (
    @(posedge mclk) disable iff (rst)
    (~$past(sync_stage2) & $past(sync_stage2, 2) & ~$past(irq_polarity) &
     $past(irq_edge_select) & $past(irq_enable_mask) & IRQ_CAP & LMASK & ~irq) ==
      32'h0000_0000)
    else $error("falling edge interrupt missing");

  a_level_follows: assert property (
    @(posedge mclk) disable iff (rst)
    ##1 ((irq ^ (~($past(sync_stage2) ^ $past(irq_polarity)) & IRQ_CAP & LMASK)) &
      ~$past(irq_edge_select) & $past(irq_enable_mask)) == 32'h0000_0000)
    else $error("level interrupt does not match input and polarity");

  a_write_output: assert property (
    @(posedge mclk) disable iff (rst)
    wr_out |=> output_value == ($past(apb_req.pwdata) & LMASK))
    else $error("output register write lost");

  a_write_dir: assert property (
    @(posedge mclk) disable iff (rst)
    wr_dir |=> line_direction == ($past(apb_req.pwdata) & LMASK))
    else $error("direction register write lost");

  a_write_pol: assert property (
    @(posedge mclk) disable iff (rst)
    wr_pol |=> irq_polarity == ($past(apb_req.pwdata) & LMASK))
    else $error("polarity register write lost");

  a_write_edge: assert property (
    @(posedge mclk) disable iff (rst)
    wr_edge |=> irq_edge_select == ($past(apb_req.pwdata) & LMASK))
    else $error("edge register write lost");

  a_read_data: assert property (
    @(posedge mclk) disable iff (rst)
    setup_rd && ofs == gpio_port_pkg::OFS_INPUT_VALUE |=>
      prdata == $past(synced_input_vector))
    else $error("data register read returns wrong value");

  // Idle read data is zero so a shared read-back bus can simply OR slaves
  a_rdata_idle: assert property (
    @(posedge mclk) disable iff (rst)
    !hit |=> prdata == 32'h0000_0000)
    else $error("read data not zero while unselected");

  a_high_bits_zero: assert property (
    @(posedge mclk) disable iff (rst)
    ((output_value | line_direction | irq_enable_mask | irq_polarity |
      irq_edge_select | alt_output_select | prdata) & ~LMASK) == 32'h0000_0000)
    else $error("bits above line count are not zero");

endmodule

// >>> verif/pad_model.sv
// Pad model: each pad shows the port's driven value when enabled, else the external level
module pad_model (
  // From the port
  input  wire logic [31:0] pad_out,
  input  wire logic [31:0] pad_oe,
  // External world
  input  wire logic [31:0] ext_level,
  // Back to the port
  output logic [31:0]      pad_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Enable taken as active high; the bench builds the port with that polarity
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the GPIO port
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] BASE = 32'h8000_0000;
  logic                    mclk;
  logic                    rst;
  gpio_port_pkg::apb_req_t req;
  logic [31:0]             prdata;
  logic [31:0]             pad_in;
  logic [31:0]             pad_out;
  logic [31:0]             pad_oe;
  logic [31:0]             alt_val;
  logic [31:0]             alt_en;
  logic [31:0]             raw_in;
  logic [31:0]             synced;
  logic [31:0]             irq;
  logic [31:0]             ext;
  logic                    pready;
  logic                    pslverr;
  logic [7:0]              pnp_vendor;
  logic [11:0]             pnp_device;
  int                      n_errors;
  int                      checks_done;
  int                      cycles;
  ////////////////////////////////////////////////////////////////////////////
  // Line count, address mask, reset style and identifiers stay at their defaults
  gpio_port_apb #(.BASE_ADDR(12'h800), .IRQ_CAP(32'h0000_000F), .SHARE_OUT(32'h0000_00F0),
    .SHARE_DIR(32'h0000_00C0), .OE_POL(1'b1)) i_dut (.mclk(mclk), .rst(rst), .apb_req(req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .alternate_output_value(alt_val), .alternate_output_enable(alt_en),
    .raw_input_vector(raw_in), .synced_input_vector(synced), .irq(irq),
    .pnp_vendor(pnp_vendor), .pnp_device(pnp_device));
  pad_model i_pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext), .pad_in(pad_in));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Runaway guard; the whole run needs under two hundred cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One idle edge before setup, so strobes are never assigned twice in a step
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    #1;
    req.psel = 1'b1;
    req.penable = 1'b0;
    req.pwrite = wr;
    req.paddr = a;
    req.pwdata = d;
    @(posedge mclk);
    #1;
    req.penable = 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    q = prdata;
    check("pslverr", 32'h0000_0000, 32'(pslverr));
    #1;
    req.psel = 1'b0;
    req.penable = 1'b0;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, BASE | 32'(ofs), d, x);
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [31:0] q);
    apb(1'b0, BASE | 32'(ofs), 32'h0000_0000, q);
  endtask
  task automatic count_pulses(input int bit_n, input logic [31:0] exp);
    logic [31:0] n;
    n = 32'h0000_0000;
    repeat (8) begin
      @(posedge mclk);
      #1;
      n = n + 32'(irq[bit_n]);
    end
    check("pulse count", exp, n);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] v;
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4), v);
      check("reset value", 32'h0000_0000, v);
      wr(8'(i * 4), 32'hFFFF_FFFF);
      rd(8'(i * 4), v);
      check("width clip", (i == 0) ? 32'h0000_0000 : 32'h0000_00FF, v);
      wr(8'(i * 4), 32'h0000_0000);
    end
    apb(1'b1, 32'h9000_0004, 32'h0000_00FF, v);
    rd(gpio_port_pkg::OFS_OUTPUT_VALUE, v);
    check("foreign base", 32'h0000_0000, v);
    rd(8'h1C, v);
    check("unmapped", 32'h0000_0000, v);
    check("vendor", 32'h0000_005A, 32'(pnp_vendor));
    check("device", 32'h0000_00A5, 32'(pnp_device));
    $display("t_regs done");
  endtask
  task automatic t_pads;
    logic [31:0] v;
    wr(gpio_port_pkg::OFS_LINE_DIRECTION, 32'h0000_000F);
    wr(gpio_port_pkg::OFS_OUTPUT_VALUE, 32'h0000_0005);
    check("pad_oe", 32'h0000_000F, pad_oe);
    check("pad_out", 32'h0000_0005, pad_out);
    ext = 32'hFFFF_FF90;
    #1;
    check("raw", 32'h0000_0095, raw_in);
    @(posedge mclk);
    #1;
    check("synced early", 32'h0000_0000, synced);
    @(posedge mclk);
    #1;
    check("synced", 32'h0000_0095, synced);
    rd(gpio_port_pkg::OFS_INPUT_VALUE, v);
    check("data reg", 32'h0000_0095, v);
    wr(gpio_port_pkg::OFS_ALT_OUTPUT_SEL, 32'h0000_00F1);
    alt_val = 32'h0000_00A0;
    alt_en = 32'h0000_00C0;
    #1;
    check("alt out", 32'h0000_00A5, pad_out);
    check("alt oe", 32'h0000_00CF, pad_oe);
    wr(gpio_port_pkg::OFS_ALT_OUTPUT_SEL, 32'h0000_0000);
    alt_en = 32'h0000_0000;
    wr(gpio_port_pkg::OFS_LINE_DIRECTION, 32'h0000_0000);
    $display("t_pads done");
  endtask
  task automatic t_irq;
    ext = 32'h0000_0000;
    wr(gpio_port_pkg::OFS_IRQ_POLARITY, 32'h0000_0002);
    wr(gpio_port_pkg::OFS_IRQ_EDGE, 32'h0000_000C);
    wr(gpio_port_pkg::OFS_IRQ_ENABLE, 32'h0000_0017);
    repeat (4) @(posedge mclk);
    #1;
    check("irq low", 32'h0000_0001, irq);
    ext = 32'h0000_00FF;
    repeat (4) @(posedge mclk);
    #1;
    check("irq high", 32'h0000_0002, irq);
    ext = 32'h0000_0000;
    count_pulses(2, 32'h0000_0001);
    wr(gpio_port_pkg::OFS_IRQ_POLARITY, 32'h0000_000E);
    ext = 32'h0000_00FF;
    count_pulses(2, 32'h0000_0001);
    ext = 32'h0000_0000;
    count_pulses(2, 32'h0000_0000);
    ext = 32'h0000_00FF;
    count_pulses(3, 32'h0000_0000);
    $display("t_irq done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    n_errors = 0;
    checks_done = 0;
    cycles = 0;
    req = '0;
    ext = 32'h0000_0000;
    alt_val = 32'h0000_0000;
    alt_en = 32'h0000_0000;
    rst = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_regs();
    t_pads();
    t_irq();
    report_and_stop();
  end
endmodule
